// ---- shared/tmc_pkg.sv ----
// Constants and carriers for the timer 2 mode / clock-out control block.
// Assumes an 8-bit special-function bus with single-cycle read and write.
`default_nettype none
package tmc_pkg;
	// Register addresses on the special-function bus
	localparam logic [7:0] ADDR_MODE_EXTRA = 8'h93;
	localparam logic [7:0] ADDR_CONTROL    = 8'hC8;
	localparam logic [7:0] ADDR_MODE       = 8'hC9;
	localparam logic [7:0] RESET_VALUE     = 8'h00;
	// Control register fields
	localparam int CTL_OVF    = 7;
	localparam int CTL_EXTF   = 6;
	localparam int CTL_B5     = 5;
	localparam int CTL_B4     = 4;
	localparam int CTL_FALL   = 3;
	localparam int CTL_RUN    = 2;
	localparam int CTL_CS0    = 1;
	localparam int CTL_CPRL   = 0;
	// Mode register fields
	localparam int MOD_SPLIT  = 7;
	localparam int MOD_LCS0   = 6;
	localparam int MOD_RISE   = 5;
	localparam int MOD_CS1    = 4;
	localparam int MOD_LRUN   = 3;
	localparam int MOD_LCLR   = 2;
	localparam int MOD_CKOE   = 1;
	localparam int MOD_MS0    = 0;
	// Extra mode register fields
	localparam int EXT_LCS1   = 7;
	localparam int EXT_IGN    = 6;
	localparam int EXT_BANK   = 5;
	localparam int EXT_CS2    = 4;
	localparam int EXT_MS1    = 3;
	// Prescaler for system clock / 12
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [7:0] BYTE_MAX   = 8'hFF;

	typedef enum logic [3:0] {
		TMC_M0   = 4'b0000,
		TMC_M1   = 4'b0001,
		TMC_M2   = 4'b0010,
		TMC_M3   = 4'b0011,
		TMC_SM0  = 4'b1000,
		TMC_SM1  = 4'b1001,
		TMC_SM2  = 4'b1010,
		TMC_SM3  = 4'b1011,
		TMC_PWM  = 4'b1100,
		TMC_RSVD = 4'b1111
	} tmc_mode_t;

	// Raw event inputs, already synchronous or synchronised
	typedef struct packed {
		logic extInt0Event;
		logic extInt2Event;
		logic timer0OverflowEvent;
		logic comparatorEdgeEvent;
		logic keypadEvent;
		logic serialTimerOverflow;
	} tmc_events_t;

	// Asynchronous level sources, synchronised inside
	typedef struct packed {
		logic countPin;
		logic triggerInputPin;
		logic serialReceiveLine;
		logic crystalPin;
		logic lowSpeedOscillator;
		logic comparatorOutput;
		logic twoWireClockLine;
	} tmc_pins_t;
endpackage : tmc_pkg
`default_nettype wire

// ---- design/tmc_timer2_ctrl.sv ----
// Timer 2 control: registers, count sources, flags, counter, clock-out.
// Assumes an 8-bit SFR bus on clk; pins arrive from outside the domain.
// What this block does
// - split clock-out toggles on low-byte overflow
// - low-byte overflow reloads from low reload
// - 16-bit clock-out rollover may raise interrupt
// - baud plus clock-out: shared rate, no overflow interrupt
// - overflow flag set unless baud select set
// - enabled trigger edges set external flag
// - bank select remaps control bits 5~4
// - baud select routes timer 2 overflows serially
// - low-byte overflow flag sticky until cleared
// - low overflow enable gates shared interrupt
// - baud use: trigger edge only flags
// - main run gates whole, or high byte
// - three-bit clock select picks count source
// - auto-clear stops low run on event
// - clock output driven only when enabled
// - mode decoded from four mode bits
// - ignore bit blocks overflow interrupt
// - three-bit capture select picks trigger input
// - clock-out frequency from reload difference
// - output toggles per overflow, half duty
`default_nettype none
module tmc_timer2_ctrl (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           sfrAddr,
	input  wire logic                 sfrWrite,
	input  wire logic [7:0]           sfrWdata,
	output logic [7:0]                sfrRdata,
	input  wire logic                 countHighWrite,
	input  wire logic                 countLowWrite,
	input  wire logic                 reloadHighWrite,
	input  wire logic                 reloadLowWrite,
	input  wire logic [7:0]           dataIn,
	output logic [7:0]                countHigh,
	output logic [7:0]                countLow,
	output logic [7:0]                reloadHigh,
	output logic [7:0]                reloadLow,
	input  wire tmc_pkg::tmc_events_t events,
	input  wire tmc_pkg::tmc_pins_t   pins,
	output logic                      clockOutPin,
	output logic                      clockOutEnable,
	output logic                      timerIrq,
	output logic                      rxUseTimer2,
	output logic                      txUseTimer2,
	output logic                      baudTick,
	output tmc_pkg::tmc_mode_t        mode
);
	logic [7:0] ctl, modr, ext, next_ctl, next_modr, next_ext;
	logic       rxSel, txSel, lowIntEn, lowFlag, next_rxSel, next_txSel;
	logic       next_lowIntEn, next_lowFlag;
	logic [6:0] sync1, sync2, sync3;
	logic [3:0] div12;
	logic [7:0] next_countHigh, next_countLow, next_reloadHigh, next_reloadLow;
	logic       next_clockOutPin;
	logic       split, baudUse, tick12, pinRise, trigFall, trigRise, trigSel, trigPrev;
	logic       hiTick, loTick, loOvf, hiOvf, fullOvf, trigEvent, capture;
	tmc_pkg::tmc_mode_t next_mode;

	// Two-flop synchronisers; third stage only for edge detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
			sync3 <= 7'h00;
			div12 <= 4'h0;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
			sync3 <= sync2;
			div12 <= (div12 == tmc_pkg::DIV12_LAST) ? 4'h0 : 4'(div12 + 4'h1);
		end
	end

	// Pin edges are caught only if slower than half of clk
	assign tick12   = (div12 == tmc_pkg::DIV12_LAST);
	assign pinRise  = sync2[6] & ~sync3[6];
	assign split    = modr[tmc_pkg::MOD_SPLIT];
	assign baudUse  = rxSel | txSel;

	// Mode decode; reserved codes fold to one value
	always_comb
	begin
		case ({split, ext[tmc_pkg::EXT_MS1], ctl[tmc_pkg::CTL_CPRL], modr[tmc_pkg::MOD_MS0]})
			4'b0000: next_mode = tmc_pkg::TMC_M0;
			4'b0001: next_mode = tmc_pkg::TMC_M1;
			4'b0010: next_mode = tmc_pkg::TMC_M2;
			4'b0011: next_mode = tmc_pkg::TMC_M3;
			4'b1000: next_mode = tmc_pkg::TMC_SM0;
			4'b1001: next_mode = tmc_pkg::TMC_SM1;
			4'b1010: next_mode = tmc_pkg::TMC_SM2;
			4'b1011: next_mode = tmc_pkg::TMC_SM3;
			4'b1100: next_mode = tmc_pkg::TMC_PWM;
			default: next_mode = tmc_pkg::TMC_RSVD;
		endcase
	end
	assign mode = next_mode;

	// Low-byte count source
	always_comb
	begin
		case ({ext[tmc_pkg::EXT_LCS1], modr[tmc_pkg::MOD_LCS0]})
			2'b00:   loTick = tick12;
			2'b01:   loTick = 1'b1;
			2'b10:   loTick = events.serialTimerOverflow;
			default: loTick = events.extInt0Event;
		endcase
	end

	// Main count source; in split, code 011 means low-byte overflow
	always_comb
	begin
		case ({ext[tmc_pkg::EXT_CS2], modr[tmc_pkg::MOD_CS1], ctl[tmc_pkg::CTL_CS0]})
			3'b000:  hiTick = tick12;
			3'b001:  hiTick = pinRise;
			3'b010:  hiTick = 1'b1;
			3'b011:  hiTick = split ? loOvf : events.extInt0Event;
			3'b101:  hiTick = events.timer0OverflowEvent;
			3'b110:  hiTick = events.comparatorEdgeEvent;
			3'b111:  hiTick = events.keypadEvent;
			default: hiTick = 1'b0;                            // Reserved: no count
		endcase
	end

	// Capture/trigger source select over synchronised levels and two event strobes
	always_comb
	begin
		case (ext[2:0])
			3'b000:  trigSel = sync2[5];
			3'b001:  trigSel = sync2[4];
			3'b010:  trigSel = sync2[3];
			3'b011:  trigSel = events.extInt2Event;
			3'b100:  trigSel = sync2[2];
			3'b101:  trigSel = sync2[1];
			3'b110:  trigSel = events.keypadEvent;
			default: trigSel = sync2[0];
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			trigPrev <= 1'b0;
		else
			trigPrev <= trigSel;
	end

	// Enabled trigger edges
	assign trigFall  = trigPrev & ~trigSel & ctl[tmc_pkg::CTL_FALL];
	assign trigRise  = ~trigPrev & trigSel & modr[tmc_pkg::MOD_RISE];
	assign trigEvent = trigFall | trigRise;
	assign capture   = trigEvent & ~baudUse;

	// Overflow detection per operation
	assign loOvf   = split & modr[tmc_pkg::MOD_LRUN] & loTick & (countLow == tmc_pkg::BYTE_MAX);
	assign hiOvf   = ctl[tmc_pkg::CTL_RUN] & hiTick & (countHigh == tmc_pkg::BYTE_MAX);
	assign fullOvf = ~split & hiOvf & (countLow == tmc_pkg::BYTE_MAX);

	// Counter, reload and capture datapath
	always_comb
	begin
		next_countHigh  = countHigh;
		next_countLow   = countLow;
		next_reloadHigh = reloadHighWrite ? dataIn : reloadHigh;
		next_reloadLow  = reloadLowWrite ? dataIn : reloadLow;
		if (split)
		begin
			if (modr[tmc_pkg::MOD_LRUN] && loTick)
				next_countLow = loOvf ? reloadLow : 8'(countLow + 8'h01);
			if (ctl[tmc_pkg::CTL_RUN] && hiTick)
				next_countHigh = hiOvf ? reloadHigh : 8'(countHigh + 8'h01);
		end
		else if (ctl[tmc_pkg::CTL_RUN] && hiTick)
		begin
			if (fullOvf)
			begin
				next_countHigh = reloadHigh;
				next_countLow  = reloadLow;
			end
			else
				{next_countHigh, next_countLow} = 16'({countHigh, countLow} + 16'h0001);
		end
		if (capture && ctl[tmc_pkg::CTL_CPRL])
		begin
			next_reloadHigh = countHigh;
			next_reloadLow  = countLow;
		end
		else if (capture && !split)
		begin
			next_countHigh = reloadHigh;
			next_countLow  = reloadLow;
		end
		if (countHighWrite)
			next_countHigh = dataIn;
		if (countLowWrite)
			next_countLow = dataIn;
	end

	// Clock output toggles per overflow for half duty
	always_comb
	begin
		next_clockOutPin = clockOutPin;
		if (split ? loOvf : fullOvf)
			next_clockOutPin = ~clockOutPin;
	end
	assign clockOutEnable = modr[tmc_pkg::MOD_CKOE];
	assign baudTick = split ? loOvf : fullOvf;
	assign rxUseTimer2 = rxSel;
	assign txUseTimer2 = txSel;

	// Register writes; hardware sets win over software clears
	always_comb
	begin
		next_ctl      = ctl;
		next_modr     = modr;
		next_ext      = ext;
		next_rxSel    = rxSel;
		next_txSel    = txSel;
		next_lowIntEn = lowIntEn;
		next_lowFlag  = lowFlag;
		if (sfrWrite && sfrAddr == tmc_pkg::ADDR_CONTROL)
		begin
			next_ctl = sfrWdata;
			if (ext[tmc_pkg::EXT_BANK])
			begin
				next_lowFlag  = sfrWdata[tmc_pkg::CTL_B5];
				next_lowIntEn = sfrWdata[tmc_pkg::CTL_B4];
			end
			else
			begin
				next_rxSel = sfrWdata[tmc_pkg::CTL_B5];
				next_txSel = sfrWdata[tmc_pkg::CTL_B4];
			end
		end
		if (sfrWrite && sfrAddr == tmc_pkg::ADDR_MODE)
			next_modr = sfrWdata;
		if (sfrWrite && sfrAddr == tmc_pkg::ADDR_MODE_EXTRA)
			next_ext = sfrWdata;
		if ((split ? hiOvf : fullOvf) && !baudUse)
			next_ctl[tmc_pkg::CTL_OVF] = 1'b1;
		if (trigEvent)
			next_ctl[tmc_pkg::CTL_EXTF] = 1'b1;
		if (loOvf)
			next_lowFlag = 1'b1;
		if (modr[tmc_pkg::MOD_LCLR]
			&& ((!ctl[tmc_pkg::CTL_CPRL] && hiOvf) || (ctl[tmc_pkg::CTL_CPRL] && capture)))
			next_modr[tmc_pkg::MOD_LRUN] = 1'b0;
	end

	// Register stage for control state and counters
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl         <= tmc_pkg::RESET_VALUE;
			modr        <= tmc_pkg::RESET_VALUE;
			ext         <= tmc_pkg::RESET_VALUE;
			rxSel       <= 1'b0;
			txSel       <= 1'b0;
			lowIntEn    <= 1'b0;
			lowFlag     <= 1'b0;
			countHigh   <= tmc_pkg::RESET_VALUE;
			countLow    <= tmc_pkg::RESET_VALUE;
			reloadHigh  <= tmc_pkg::RESET_VALUE;
			reloadLow   <= tmc_pkg::RESET_VALUE;
			clockOutPin <= 1'b0;
		end
		else
		begin
			ctl         <= next_ctl;
			modr        <= next_modr;
			ext         <= next_ext;
			rxSel       <= next_rxSel;
			txSel       <= next_txSel;
			lowIntEn    <= next_lowIntEn;
			lowFlag     <= next_lowFlag;
			countHigh   <= next_countHigh;
			countLow    <= next_countLow;
			reloadHigh  <= next_reloadHigh;
			reloadLow   <= next_reloadLow;
			clockOutPin <= next_clockOutPin;
		end
	end

	// Interrupt: baud use masks overflow; ignore bit blocks it too
	assign timerIrq = (ctl[tmc_pkg::CTL_OVF] & ~ext[tmc_pkg::EXT_IGN] & ~baudUse)
		| ctl[tmc_pkg::CTL_EXTF]
		| (lowFlag & lowIntEn);

	// Read mux; bits 5~4 of control follow the bank select
	always_comb
	begin
		case (sfrAddr)
			tmc_pkg::ADDR_CONTROL:
				sfrRdata = ext[tmc_pkg::EXT_BANK] ? {ctl[7:6], lowFlag, lowIntEn, ctl[3:0]}
					: {ctl[7:6], rxSel, txSel, ctl[3:0]};
			tmc_pkg::ADDR_MODE:       sfrRdata = modr;
			tmc_pkg::ADDR_MODE_EXTRA: sfrRdata = ext;
			default:                  sfrRdata = 8'h00;
		endcase
	end

	AST_OVF_SET: assert property (@(posedge clk) disable iff (!arst_n)
		(fullOvf && !baudUse) |=> ctl[tmc_pkg::CTL_OVF]) else $error("overflow flag not set");
	AST_OVF_BAUD: assert property (@(posedge clk) disable iff (!arst_n)
		(baudUse && $rose(ctl[tmc_pkg::CTL_OVF])) |-> $past(sfrWrite)) else $error("flag set in baud use");
	AST_LOW_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
		loOvf |=> lowFlag) else $error("low flag missed");
	AST_LOW_RELOAD: assert property (@(posedge clk) disable iff (!arst_n)
		(loOvf && !countLowWrite) |=> countLow == $past(reloadLow)) else $error("low reload missed");
	AST_TOGGLE: assert property (@(posedge clk) disable iff (!arst_n)
		(split && loOvf) |=> clockOutPin != $past(clockOutPin)) else $error("no toggle");
	AST_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
		(ext[tmc_pkg::EXT_IGN] && !ctl[tmc_pkg::CTL_EXTF] && !lowFlag) |-> !timerIrq) else $error("ignored irq");
	AST_EXT_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
		trigEvent |=> ctl[tmc_pkg::CTL_EXTF]) else $error("external flag missed");
	AST_AUTOCLR: assert property (@(posedge clk) disable iff (!arst_n)
		(modr[tmc_pkg::MOD_LCLR] && !ctl[tmc_pkg::CTL_CPRL] && hiOvf && !sfrWrite)
		|=> !modr[tmc_pkg::MOD_LRUN]) else $error("low run not cleared");
	AST_RUN: assert property (@(posedge clk) disable iff (!arst_n)
		(!split && !ctl[tmc_pkg::CTL_RUN] && !capture && !countHighWrite) |=> $stable(countHigh))
		else $error("counted while stopped");
endmodule : tmc_timer2_ctrl
`default_nettype wire

// ---- test/tmc_timer2_ctrl_tb.sv ----
// Self-checking bench for the timer 2 control block.
// Assumes combinational SFR reads and registered SFR writes on clk.
`default_nettype none
module tmc_timer2_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] AX = tmc_pkg::ADDR_MODE_EXTRA;
	localparam logic [7:0] AC = tmc_pkg::ADDR_CONTROL;
	localparam logic [7:0] AM = tmc_pkg::ADDR_MODE;
	logic                 clk       = 1'b0;
	logic                 arst_n    = 1'b0;
	logic [7:0]           sfrAddr   = 8'h00;
	logic                 sfrWrite  = 1'b0;
	logic [7:0]           sfrWdata  = 8'h00;
	logic [3:0]           ldStb     = 4'h0;
	logic [7:0]           dataIn    = 8'h00;
	tmc_pkg::tmc_events_t events    = '0;
	tmc_pkg::tmc_pins_t   pins      = '0;
	logic [2:0]           evtCnt    = 3'h0;
	logic [7:0]           sfrRdata, countHigh, countLow, reloadHigh, reloadLow, rv;
	logic                 clockOutPin, clockOutEnable, timerIrq;
	logic                 rxUseTimer2, txUseTimer2, baudTick;
	tmc_pkg::tmc_mode_t   mode;
	int                   errCount  = 0;
	int                   nCompared = 0;
	int                   n;
	int                   expCnt[8] = '{5, 14, 60, 12, 0, 12, 12, 12};
	int                   lowGap[4] = '{24, 2, 10, 10};
	int                   pinIx[8]  = '{5, 4, 3, -1, 2, 1, -1, 0};

	tmc_timer2_ctrl u_tmc_timer2_ctrl (
		.clk(clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .countHighWrite(ldStb[3]),
		.countLowWrite(ldStb[2]), .reloadHighWrite(ldStb[1]), .reloadLowWrite(ldStb[0]),
		.dataIn(dataIn), .countHigh(countHigh), .countLow(countLow),
		.reloadHigh(reloadHigh), .reloadLow(reloadLow), .events(events), .pins(pins),
		.clockOutPin(clockOutPin), .clockOutEnable(clockOutEnable), .timerIrq(timerIrq),
		.rxUseTimer2(rxUseTimer2), .txUseTimer2(txUseTimer2), .baudTick(baudTick),
		.mode(mode)
	);

	// Free-running clock
	initial
	begin
		forever #2 clk = ~clk;
	end

	// All event strobes pulse every fifth cycle, so counts over a window are exact
	always @(negedge clk)
	begin
		evtCnt <= (evtCnt == 3'h4) ? 3'h0 : evtCnt + 3'h1;
		events <= {6{evtCnt == 3'h0}};
	end

	function automatic logic [7:0] bt(input int i);
		return 8'h01 << i;
	endfunction : bt

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		nCompared++;
		if (got !== exp)
		begin
			errCount++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One SFR write; strobe drops a full cycle before the next call raises it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		@(negedge clk);
		sfrWrite = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		#1 d = sfrRdata;
	endtask : rd

	// Counter and reload loads: 3 count high, 2 count low, 1 reload high, 0 reload low
	task automatic ld(input int i, input logic [7:0] d);
		@(negedge clk);
		dataIn = d;
		ldStb[i] = 1'b1;
		@(negedge clk);
		ldStb = 4'h0;
	endtask : ld

	// Low run stopped first so no overflow re-sets a flag behind the clears;
	// control written under the current bank select and then under bank 0, so both meanings of bits 5~4 get zeroed only when the bank was set
	task automatic clr();
		wr(AM, 8'h00);
		wr(AC, 8'h00);
		wr(AX, 8'h00);
		wr(AC, 8'h00);
	endtask : clr

	// Measures two successive half periods of the clock output
	task automatic gap(input int exp);
		logic l;
		int   k;
		for (int h = 0; h < 3; h++)
		begin
			@(negedge clk);
			l = clockOutPin;
			k = 1;
			while (clockOutPin === l && k < 100)
			begin
				@(negedge clk);
				k++;
			end
			if (h > 0)
				chk("half period", 16'(exp), 16'(k));
		end
	endtask : gap

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Watchdog well beyond the expected run of roughly 1400 cycles
	initial
	begin
		#100000;
		errCount++;
		tally_and_finish();
	end

	initial
	begin
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		// Reset values, readback, unmapped address
		foreach (expCnt[i])
			if (i < 3)
			begin
				rd((i == 0) ? AX : (i == 1) ? AC : AM, rv);
				chk("reset value", tmc_pkg::RESET_VALUE, rv);
			end
		wr(AM, 8'hA5);
		wr(AX, 8'h5A);
		wr(8'hC7, 8'hFF);
		rd(AM, rv);
		chk("mode reg", 8'hA5, rv);
		rd(AX, rv);
		chk("extra reg", 8'h5A, rv);
		rd(8'hC7, rv);
		chk("unmapped", 8'h00, rv);
		clr();
		// Every mode code, reserved ones included
		for (int c = 0; c < 16; c++)
		begin
			wr(AM, {c[3], 6'h00, c[0]});
			wr(AX, {4'h0, c[2], 3'h0});
			wr(AC, {7'h00, c[1]});
			chk("mode", (c < 4 || (c > 7 && c < 13)) ? 16'(c) : 16'h000F, {12'h000, mode});
		end
		clr();
		// Counts over a 60-cycle run window per clock select code; pin at a quarter of clk
		for (int c = 0; c < 8; c++)
		begin
			ld(3, 8'h00);
			ld(2, 8'h00);
			wr(AX, {3'h0, c[2], 4'h0});
			wr(AM, {3'h0, c[1], 4'h0});
			wr(AC, {5'h00, 1'b1, c[0], 1'b0});
			for (int k = 0; k < 58; k++)
			begin
				@(negedge clk);
				pins.countPin = (c == 1) && k[1];
			end
			wr(AC, 8'h00);
			chk("count", 16'(expCnt[c]), {countHigh, countLow});
		end
		clr();
		// 16-bit clock-out, reload 0xFFFC gives four counts per half period
		ld(1, 8'hFF);
		ld(0, 8'hFC);
		ld(3, 8'hFF);
		ld(2, 8'hFC);
		chk("reload", 16'hFFFC, {reloadHigh, reloadLow});
		wr(AM, bt(tmc_pkg::MOD_CS1) | bt(tmc_pkg::MOD_CKOE));
		wr(AC, bt(tmc_pkg::CTL_RUN));
		chk("clock out enable", 1'b1, clockOutEnable);
		gap(4);
		rd(AC, rv);
		chk("overflow flag", 1'b1, rv[tmc_pkg::CTL_OVF]);
		chk("irq", 1'b1, timerIrq);
		wr(AX, bt(tmc_pkg::EXT_IGN));
		chk("irq ignored", 1'b0, timerIrq);
		wr(AX, 8'h00);
		// Baud use together with clock-out, trigger on falling edge only
		// Stop, then restart: the restart write clears a flag set on the stop edge
		wr(AC, bt(5) | bt(4) | bt(tmc_pkg::CTL_FALL));
		wr(AC, bt(5) | bt(4) | bt(tmc_pkg::CTL_RUN) | bt(tmc_pkg::CTL_FALL));
		chk("rx select", 1'b1, rxUseTimer2);
		chk("tx select", 1'b1, txUseTimer2);
		n = 0;
		repeat (40)
		begin
			@(negedge clk);
			if (baudTick === 1'b1)
				n++;
		end
		chk("baud ticks", 16'd10, 16'(n));
		gap(4);
		rd(AC, rv);
		chk("overflow flag", 1'b0, rv[tmc_pkg::CTL_OVF]);
		chk("irq", 1'b0, timerIrq);
		pins.triggerInputPin = 1'b1;
		repeat (6) @(negedge clk);
		rd(AC, rv);
		chk("ext flag", 1'b0, rv[tmc_pkg::CTL_EXTF]);
		pins.triggerInputPin = 1'b0;
		repeat (6) @(negedge clk);
		rd(AC, rv);
		chk("ext flag", 1'b1, rv[tmc_pkg::CTL_EXTF]);
		chk("irq", 1'b1, timerIrq);
		clr();
		// Split clock-out for each low clock select, reload 0xFE
		for (int c = 0; c < 4; c++)
		begin
			wr(AX, {c[1], 1'b0, 1'b1, 5'h00});
			ld(0, 8'hFE);
			ld(2, 8'hFE);
			ld(3, 8'h12);
			wr(AM, {1'b1, c[0], 6'h02});
			wr(AM, {1'b1, c[0], 6'h0A});
			gap(lowGap[c]);
			chk("high byte held", 8'h12, countHigh);
			rd(AC, rv);
			chk("low flag", 1'b1, rv[5]);
			chk("irq", 1'b0, timerIrq);
			wr(AC, bt(4));
			repeat (30) @(negedge clk);
			chk("irq", 1'b1, timerIrq);
			wr(AC, 8'h00);
			chk("irq", 1'b0, timerIrq);
			clr();
		end
		// Rising edge on every capture source
		for (int c = 0; c < 8; c++)
		begin
			wr(AX, {5'h00, c[2:0]});
			wr(AM, bt(tmc_pkg::MOD_RISE));
			wr(AC, 8'h00);
			if (pinIx[c] >= 0)
			begin
				rd(AC, rv);
				chk("ext flag", 1'b0, rv[tmc_pkg::CTL_EXTF]);
				pins[pinIx[c]] = 1'b1;
			end
			repeat (8) @(negedge clk);
			rd(AC, rv);
			chk("ext flag", 1'b1, rv[tmc_pkg::CTL_EXTF]);
			pins = '0;
			clr();
		end
		// High byte overflow clears low run only with auto-clear set
		for (int c = 0; c < 2; c++)
		begin
			ld(3, 8'hFD);
			wr(AM, {1'b1, 2'h0, 1'b1, 1'b1, c[0], 2'h0});
			wr(AC, bt(tmc_pkg::CTL_RUN));
			repeat (10) @(negedge clk);
			rd(AM, rv);
			chk("low run", {15'h0000, ~c[0]}, {15'h0000, rv[tmc_pkg::MOD_LRUN]});
			clr();
		end
		tally_and_finish();
	end
endmodule : tmc_timer2_ctrl_tb
`default_nettype wire
